/* File: src/fifo_pkg.sv */
package fifo_pkg;
  localparam int          A_WIDTH     = 36;
  localparam int          HALF_WIDTH  = 18;
  localparam int          DEPTH       = 256;
  // preset offset choices taken at master reset
  localparam logic [1:0]  OFS_SEL_8   = 2'h0;
  localparam logic [1:0]  OFS_SEL_16  = 2'h1;
  localparam logic [1:0]  OFS_SEL_64  = 2'h2;
  localparam int          OFS_8       = 8;
  localparam int          OFS_16      = 16;
  localparam int          OFS_64      = 64;
  // pin levels
  localparam logic        BIG_ENDIAN  = 1'b1;
  localparam logic        STD_TIMING  = 1'b1;
  // positions in the synchronised control vector
  localparam int          CTL_WIDTH   = 14;
  localparam int          CTL_A_CLK   = 0;
  localparam int          CTL_B_CLK   = 1;
  localparam int          CTL_C_CLK   = 2;
  localparam int          CTL_MR1_N   = 3;
  localparam int          CTL_MR2_N   = 4;
  localparam int          CTL_ENDIAN  = 5;
  localparam int          CTL_OFS_LO  = 6;
  localparam int          CTL_OFS_HI  = 7;
  localparam int          CTL_A_SEL_N = 8;
  localparam int          CTL_A_EN    = 9;
  localparam int          CTL_A_WR    = 10;
  localparam int          CTL_B_SEL_N = 11;
  localparam int          CTL_C_WE    = 12;
  localparam int          CTL_SPARE   = 13;
endpackage

/* File: src/pin_sync.sv */
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;
endmodule

/* File: src/word_queue.sv */
module word_queue #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 256,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_i,
  input  wire logic             clear_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [CW-1:0]    count_o,
  output logic      [CW-1:0]    free_o,
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push_ok;
  logic             pop_ok;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign full_o  = (count_r == CW'(DEPTH));
  assign empty_o = (count_r == '0);
  assign push_ok = push_i & ~full_o;   // [RULE24]
  assign pop_ok  = pop_i & ~empty_o;   // [RULE24]
  assign head_o  = mem_r[rd_ptr_r];
  assign count_o = count_r;
  assign free_o  = CW'(DEPTH) - count_r;

  always_ff @(posedge clk_i) begin
    if (push_ok) begin
      mem_r[wr_ptr_r] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      wr_ptr_r <= '0;  // [RULE22]
      rd_ptr_r <= '0;  // [RULE22]
      count_r  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop_ok) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      count_r <= count_r + CW'(push_ok) - CW'(pop_ok);
    end
  end
endmodule

/* File: src/bus_matching_fifo.sv */
// How it works
// [RULE1] port a writes a-to-b, reads c-to-a
// [RULE2] port a almost-empty low at count<=offset
// [RULE3] port b almost-empty low at count<=offset
// [RULE4] port a almost-full low at free<=offset
// [RULE5] port c almost-full low at free<=offset
// [RULE6] port b: 18-bit output from a-to-b
// [RULE7] port c: 18-bit input into c-to-a
// [RULE8] select high at reset: big endian
// [RULE9] select low at reset: little endian
// [RULE10] after reset: high standard, low fall-through
// [RULE11] controller keeps the select pin static
// [RULE12] port a flags move on port a edges
// [RULE13] port b flags move on port b edges
// [RULE14] port c flags move on port c edges
// [RULE15] port a acts when selected and enabled
// [RULE16] port a drivers off when deselected
// [RULE17] port b reads when selected, else off
// [RULE18] port a empty/ready by timing mode
// [RULE19] port b empty/ready by timing mode
// [RULE20] port a full/ready by timing mode
// [RULE21] port c full/ready by timing mode
// [RULE22] master reset clears pointers and output register
// [RULE23] preset offsets of 8, 16 or 64
// [RULE24] writes when full, reads when empty ignored
module bus_matching_fifo #(
  parameter int DEPTH = fifo_pkg::DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           port_a_clock_i,
  input  wire logic                           port_b_clock_i,
  input  wire logic                           port_c_clock_i,
  input  wire logic                           queue_one_master_reset_n_i,
  input  wire logic                           queue_two_master_reset_n_i,
  input  wire logic                           endian_timing_select_i,
  input  wire logic [1:0]                     offset_select_i,
  input  wire logic                           port_a_select_n_i,
  input  wire logic                           port_a_enable_i,
  input  wire logic                           port_a_write_i,
  input  wire logic [fifo_pkg::A_WIDTH-1:0]   port_a_data_i,
  output logic      [fifo_pkg::A_WIDTH-1:0]   port_a_data_o,
  output logic                                port_a_data_oe_o,
  output logic                                port_a_empty_or_out_ready_o,
  output logic                                port_a_full_or_in_ready_o,
  output logic                                port_a_almost_empty_n_o,
  output logic                                port_a_almost_full_n_o,
  input  wire logic                           port_b_select_n_i,
  output logic      [fifo_pkg::HALF_WIDTH-1:0] port_b_data_o,
  output logic                                port_b_data_oe_o,
  output logic                                port_b_empty_or_out_ready_o,
  output logic                                port_b_almost_empty_n_o,
  input  wire logic                           port_c_write_enable_i,
  input  wire logic [fifo_pkg::HALF_WIDTH-1:0] port_c_data_i,
  output logic                                port_c_full_or_in_ready_o,
  output logic                                port_c_almost_full_n_o
);
  localparam int AW = fifo_pkg::A_WIDTH;
  localparam int HW = fifo_pkg::HALF_WIDTH;
  // selects read as deselected until the pins have been sampled, so no data driver glitches on after reset
  localparam logic [fifo_pkg::CTL_WIDTH-1:0] CTL_IDLE =
    fifo_pkg::CTL_WIDTH'((1 << fifo_pkg::CTL_A_SEL_N) | (1 << fifo_pkg::CTL_B_SEL_N));

  logic [fifo_pkg::CTL_WIDTH-1:0] ctl_s;
  logic [AW-1:0] a_data_s;
  logic [HW-1:0] c_data_s;
  logic          a_clk_d_r, b_clk_d_r, c_clk_d_r;
  logic          a_edge, b_edge, c_edge;
  logic          a_upd_r, b_upd_r, c_upd_r;
  logic          q1_clr, q2_clr;
  logic          big_endian_r, fall_through_mode_r;
  logic [CW-1:0] port_a_empty_offset_r, port_b_empty_offset_r;
  logic [CW-1:0] port_a_full_offset_r, port_c_full_offset_r;
  logic [AW-1:0] q1_head, q2_head;
  logic [CW-1:0] q1_count, q1_free, q2_count, q2_free;
  logic          q1_full, q1_empty, q2_full, q2_empty;
  logic          a_qual, a_rd_req, a_wr_req, a_load, a_valid_r;
  logic          b_rd_req, b_load, b_valid_r, b_half_r;
  logic          c_wr, c_half_r, q2_push;
  logic [HW-1:0] c_hold_r;
  logic [AW-1:0] c_word;

  function automatic logic [CW-1:0] preset(input logic [1:0] sel);
    case (sel)
      fifo_pkg::OFS_SEL_8:  preset = CW'(fifo_pkg::OFS_8);
      fifo_pkg::OFS_SEL_16: preset = CW'(fifo_pkg::OFS_16);
      default:              preset = CW'(fifo_pkg::OFS_64);
    endcase
  endfunction

  function automatic logic [HW-1:0] pick_half(input logic [AW-1:0] w, input logic hi);
    pick_half = hi ? w[AW-1:HW] : w[HW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and port clock edges
  pin_sync #(.W(fifo_pkg::CTL_WIDTH), .RST_VAL(CTL_IDLE)) u_ctl_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({1'b0, port_c_write_enable_i, port_b_select_n_i, port_a_write_i, port_a_enable_i,
                 port_a_select_n_i, offset_select_i, endian_timing_select_i, queue_two_master_reset_n_i,
                 queue_one_master_reset_n_i, port_c_clock_i, port_b_clock_i, port_a_clock_i}),
    .q_o       (ctl_s)
  );

  pin_sync #(.W(AW)) u_a_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (port_a_data_i),
    .q_o       (a_data_s)
  );

  pin_sync #(.W(HW)) u_c_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (port_c_data_i),
    .q_o       (c_data_s)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      a_clk_d_r <= 1'b0;
      b_clk_d_r <= 1'b0;
      c_clk_d_r <= 1'b0;
      a_upd_r   <= 1'b0;
      b_upd_r   <= 1'b0;
      c_upd_r   <= 1'b0;
    end else begin
      a_clk_d_r <= ctl_s[fifo_pkg::CTL_A_CLK];
      b_clk_d_r <= ctl_s[fifo_pkg::CTL_B_CLK];
      c_clk_d_r <= ctl_s[fifo_pkg::CTL_C_CLK];
      a_upd_r   <= a_edge;
      b_upd_r   <= b_edge;
      c_upd_r   <= c_edge;
    end
  end

  assign a_edge = ctl_s[fifo_pkg::CTL_A_CLK] & ~a_clk_d_r;
  assign b_edge = ctl_s[fifo_pkg::CTL_B_CLK] & ~b_clk_d_r;
  assign c_edge = ctl_s[fifo_pkg::CTL_C_CLK] & ~c_clk_d_r;
  assign q1_clr = sys_rst_i | ~ctl_s[fifo_pkg::CTL_MR1_N];
  assign q2_clr = sys_rst_i | ~ctl_s[fifo_pkg::CTL_MR2_N];

  ////////////////////////////////////////////////////////////////////////////////
  // endian and offsets caught at master reset, timing mode tracked after it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      big_endian_r          <= 1'b0;
      fall_through_mode_r   <= 1'b0;
      port_a_empty_offset_r <= CW'(fifo_pkg::OFS_8);
      port_b_empty_offset_r <= CW'(fifo_pkg::OFS_8);
      port_a_full_offset_r  <= CW'(fifo_pkg::OFS_8);
      port_c_full_offset_r  <= CW'(fifo_pkg::OFS_8);
    end else if (~ctl_s[fifo_pkg::CTL_MR1_N]) begin
      big_endian_r          <= (ctl_s[fifo_pkg::CTL_ENDIAN] == fifo_pkg::BIG_ENDIAN);  // [RULE8] [RULE9]
      port_a_empty_offset_r <= preset(ctl_s[fifo_pkg::CTL_OFS_HI:fifo_pkg::CTL_OFS_LO]);  // [RULE23]
      port_b_empty_offset_r <= preset(ctl_s[fifo_pkg::CTL_OFS_HI:fifo_pkg::CTL_OFS_LO]);  // [RULE23]
      port_a_full_offset_r  <= preset(ctl_s[fifo_pkg::CTL_OFS_HI:fifo_pkg::CTL_OFS_LO]);  // [RULE23]
      port_c_full_offset_r  <= preset(ctl_s[fifo_pkg::CTL_OFS_HI:fifo_pkg::CTL_OFS_LO]);  // [RULE23]
    end else begin
      // pin is held static from here on by the controller
      fall_through_mode_r   <= (ctl_s[fifo_pkg::CTL_ENDIAN] != fifo_pkg::STD_TIMING);  // [RULE10] [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // queues
  assign a_qual   = ~ctl_s[fifo_pkg::CTL_A_SEL_N] & ctl_s[fifo_pkg::CTL_A_EN];  // [RULE15]
  assign a_wr_req = a_edge & a_qual & ctl_s[fifo_pkg::CTL_A_WR];                  // [RULE1]
  assign a_rd_req = a_edge & a_qual & ~ctl_s[fifo_pkg::CTL_A_WR];                 // [RULE1]

  word_queue #(.WIDTH(AW), .DEPTH(DEPTH), .CW(CW)) u_a_to_b_queue (
    .clk_i       (clk_i),
    .clear_i     (q1_clr),
    .push_i      (a_wr_req),
    .push_data_i (a_data_s),
    .pop_i       (b_load & b_half_r),
    .head_o      (q1_head),
    .count_o     (q1_count),
    .free_o      (q1_free),
    .full_o      (q1_full),
    .empty_o     (q1_empty)
  );

  word_queue #(.WIDTH(AW), .DEPTH(DEPTH), .CW(CW)) u_c_to_a_queue (
    .clk_i       (clk_i),
    .clear_i     (q2_clr),
    .push_i      (q2_push),
    .push_data_i (c_word),
    .pop_i       (a_load),
    .head_o      (q2_head),
    .count_o     (q2_count),
    .free_o      (q2_free),
    .full_o      (q2_full),
    .empty_o     (q2_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // port a read path and flags
  // fall-through preloads the output register without a read
  assign a_load = ~q2_empty & (fall_through_mode_r ? (a_edge & (~a_valid_r | a_rd_req)) : a_rd_req);  // [RULE24]

  always_ff @(posedge clk_i) begin
    if (q2_clr) begin
      port_a_data_o <= '0;  // [RULE22]
      a_valid_r     <= 1'b0;
    end else if (a_load) begin
      port_a_data_o <= q2_head;  // [RULE1]
      a_valid_r     <= 1'b1;
    end else if (a_rd_req) begin
      a_valid_r     <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_a_data_oe_o <= 1'b0;
    end else begin
      port_a_data_oe_o <= ~ctl_s[fifo_pkg::CTL_A_SEL_N] & ~ctl_s[fifo_pkg::CTL_A_WR];  // [RULE16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_a_empty_or_out_ready_o <= 1'b0;
      port_a_full_or_in_ready_o   <= 1'b0;
      port_a_almost_empty_n_o     <= 1'b0;
      port_a_almost_full_n_o      <= 1'b0;
    end else if (a_upd_r) begin  // [RULE12]
      port_a_empty_or_out_ready_o <= fall_through_mode_r ? a_valid_r : ~q2_empty;  // [RULE18]
      port_a_full_or_in_ready_o   <= ~q1_full;                                     // [RULE20]
      port_a_almost_empty_n_o     <= (q2_count > port_a_empty_offset_r);           // [RULE2]
      port_a_almost_full_n_o      <= (q1_free > port_a_full_offset_r);             // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port b read path, two halves per word
  assign b_rd_req = b_edge & ~ctl_s[fifo_pkg::CTL_B_SEL_N];  // [RULE17]
  assign b_load   = ~q1_empty & (fall_through_mode_r ? (b_edge & (~b_valid_r | b_rd_req)) : b_rd_req);

  always_ff @(posedge clk_i) begin
    if (q1_clr) begin
      port_b_data_o <= '0;  // [RULE22]
      b_valid_r     <= 1'b0;
      b_half_r      <= 1'b0;
    end else if (b_load) begin
      port_b_data_o <= pick_half(q1_head, big_endian_r ^ b_half_r);  // [RULE6] [RULE8] [RULE9]
      b_valid_r     <= 1'b1;
      b_half_r      <= ~b_half_r;
    end else if (b_rd_req) begin
      b_valid_r     <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_b_data_oe_o            <= 1'b0;
      port_b_empty_or_out_ready_o <= 1'b0;
      port_b_almost_empty_n_o     <= 1'b0;
    end else begin
      port_b_data_oe_o <= ~ctl_s[fifo_pkg::CTL_B_SEL_N];  // [RULE17]
      if (b_upd_r) begin  // [RULE13]
        port_b_empty_or_out_ready_o <= fall_through_mode_r ? b_valid_r : ~q1_empty;  // [RULE19]
        port_b_almost_empty_n_o     <= (q1_count > port_b_empty_offset_r);           // [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port c write path, two halves build one word
  assign c_wr    = c_edge & ctl_s[fifo_pkg::CTL_C_WE] & ~q2_full;  // [RULE24]
  assign q2_push = c_wr & c_half_r;
  assign c_word  = big_endian_r ? {c_hold_r, c_data_s} : {c_data_s, c_hold_r};  // [RULE7] [RULE8] [RULE9]

  always_ff @(posedge clk_i) begin
    if (q2_clr) begin
      c_half_r <= 1'b0;
      c_hold_r <= '0;
    end else if (c_wr) begin
      c_half_r <= ~c_half_r;
      if (~c_half_r) begin
        c_hold_r <= c_data_s;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_c_full_or_in_ready_o <= 1'b0;
      port_c_almost_full_n_o    <= 1'b0;
    end else if (c_upd_r) begin  // [RULE14]
      port_c_full_or_in_ready_o <= ~q2_full;                          // [RULE21]
      port_c_almost_full_n_o    <= (q2_free > port_c_full_offset_r);  // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_a_tick;  a_upd_r; endsequence
  sequence s_b_tick;  b_upd_r; endsequence
  sequence s_c_tick;  c_upd_r; endsequence

  property p_a_ae;   s_a_tick |=> port_a_almost_empty_n_o == ($past(q2_count) > $past(port_a_empty_offset_r)); endproperty
  a_a_ae:   assert property (p_a_ae)   else $error("port a almost-empty wrong");  // [RULE2]
  property p_b_ae;   s_b_tick |=> port_b_almost_empty_n_o == ($past(q1_count) > $past(port_b_empty_offset_r)); endproperty
  a_b_ae:   assert property (p_b_ae)   else $error("port b almost-empty wrong");  // [RULE3]
  property p_a_af;   s_a_tick |=> port_a_almost_full_n_o == ($past(q1_free) > $past(port_a_full_offset_r)); endproperty
  a_a_af:   assert property (p_a_af)   else $error("port a almost-full wrong");  // [RULE4]
  property p_c_af;   s_c_tick |=> port_c_almost_full_n_o == ($past(q2_free) > $past(port_c_full_offset_r)); endproperty
  a_c_af:   assert property (p_c_af)   else $error("port c almost-full wrong");  // [RULE5]
  property p_a_hold; !a_upd_r |=> $stable({port_a_empty_or_out_ready_o, port_a_full_or_in_ready_o,
                                           port_a_almost_empty_n_o, port_a_almost_full_n_o}); endproperty
  a_a_hold: assert property (p_a_hold) else $error("port a flag moved off edge");  // [RULE12]
  property p_b_hold; !b_upd_r |=> $stable({port_b_empty_or_out_ready_o, port_b_almost_empty_n_o}); endproperty
  a_b_hold: assert property (p_b_hold) else $error("port b flag moved off edge");  // [RULE13]
  property p_c_hold; !c_upd_r |=> $stable({port_c_full_or_in_ready_o, port_c_almost_full_n_o}); endproperty
  a_c_hold: assert property (p_c_hold) else $error("port c flag moved off edge");  // [RULE14]
  property p_a_off;  ctl_s[fifo_pkg::CTL_A_SEL_N] |=> !port_a_data_oe_o; endproperty
  a_a_off:  assert property (p_a_off)  else $error("port a driven while deselected");  // [RULE16]
  property p_a_push; q1_count > $past(q1_count) |-> $past(a_wr_req) && !$past(q1_full); endproperty
  a_a_push: assert property (p_a_push) else $error("a-to-b grew without a qualified write");  // [RULE15]
  property p_a_std;  s_a_tick ##0 !fall_through_mode_r |=> port_a_empty_or_out_ready_o == !$past(q2_empty); endproperty
  a_a_std:  assert property (p_a_std)  else $error("port a empty flag wrong");  // [RULE18]
endmodule

/* File: verification/port_agent.sv */
module port_agent (
  input  wire logic        clk_i,
  output logic             port_a_clock_o,
  output logic             port_b_clock_o,
  output logic             port_c_clock_o,
  output logic             a_sel_n_o,
  output logic             a_en_o,
  output logic             a_wr_o,
  output logic [35:0]      a_drv_o,
  input  wire logic [35:0] a_wire_i,
  input  wire logic        a_oe_i,
  output logic             b_sel_n_o,
  input  wire logic [17:0] b_data_i,
  input  wire logic        b_oe_i,
  output logic             c_we_o,
  output logic [17:0]      c_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  // free-running port clocks of 8, 10 and 12 system cycles with staggered phases
  always @(negedge clk_i) begin
    ph <= ph + 1;
  end
  assign port_a_clock_o = (ph % 8) < 4;
  assign port_b_clock_o = ((ph + 3) % 10) < 5;
  assign port_c_clock_o = ((ph + 7) % 12) < 6;
  initial begin
    a_sel_n_o = 1'b1;
    a_en_o    = 1'b0;
    a_wr_o    = 1'b0;
    a_drv_o   = 36'h0;
    b_sel_n_o = 1'b1;
    c_we_o    = 1'b0;
    c_data_o  = 18'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // fall-through data is taken at the edge itself, standard data after it lands
  task automatic a_op(input logic sel_n, input logic en, input logic wr, input logic [35:0] d,
                      input logic fall_through_mode, output logic [35:0] q, output logic oe);
    @(negedge port_a_clock_o);
    a_sel_n_o = sel_n;
    a_en_o    = en;
    a_wr_o    = wr;
    a_drv_o   = wr ? d : ~a_drv_o;
    @(posedge port_a_clock_o);
    repeat (fall_through_mode ? 0 : 6) @(negedge clk_i);
    q  = a_wire_i;
    oe = a_oe_i;
    repeat (fall_through_mode ? 6 : 0) @(negedge clk_i);
    a_sel_n_o = 1'b1;
    a_en_o    = 1'b0;
    a_drv_o   = ~a_drv_o;
  endtask
  task automatic b_read(input logic fall_through_mode, output logic [17:0] q, output logic oe);
    @(negedge port_b_clock_o);
    b_sel_n_o = 1'b0;
    @(posedge port_b_clock_o);
    repeat (fall_through_mode ? 0 : 6) @(negedge clk_i);
    q  = b_data_i;
    oe = b_oe_i;
    repeat (fall_through_mode ? 6 : 0) @(negedge clk_i);
    b_sel_n_o = 1'b1;
  endtask
  task automatic c_write(input logic [17:0] d);
    @(negedge port_c_clock_o);
    c_we_o   = 1'b1;
    c_data_o = d;
    @(posedge port_c_clock_o);
    // release before the falling port c edge that the next call waits for
    repeat (5) @(negedge clk_i);
    c_we_o   = 1'b0;
    c_data_o = ~d;
  endtask
endmodule

/* File: verification/bus_matching_fifo_tb.sv */
module bus_matching_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 128;
  typedef struct {
    logic       endian;
    logic [1:0] ofs_sel;
    int         ofs;
  } row_s;
  row_s rows [3] = '{'{fifo_pkg::BIG_ENDIAN, fifo_pkg::OFS_SEL_8, fifo_pkg::OFS_8},
                     '{1'b0, fifo_pkg::OFS_SEL_16, fifo_pkg::OFS_16},
                     '{fifo_pkg::BIG_ENDIAN, fifo_pkg::OFS_SEL_64, fifo_pkg::OFS_64}};
  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic             mrst1_n = 1'b0;
  logic             mrst2_n = 1'b0;
  logic             endian_sel = fifo_pkg::BIG_ENDIAN;
  logic [1:0]       offset_sel = 2'h0;
  int               err_total = 0;
  int               num_checks = 0;
  logic             big, fall_through_mode, oe;
  logic [35:0]      q36, w;
  logic [17:0]      q18;
  wire logic        a_clk, b_clk, c_clk, a_sel_n, a_en, a_dir, a_oe, b_sel_n, b_oe, c_we;
  wire logic        a_ef, a_ff, a_ae_n, a_af_n, b_ef, b_ae_n, c_ff, c_af_n;
  wire logic [35:0] a_drv, a_q;
  wire logic [17:0] b_q, c_d;
  wire logic [35:0] a_wire = a_oe ? a_q : a_drv;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  bus_matching_fifo #(.DEPTH(DEPTH)) bus_matching_fifo_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .port_a_clock_i(a_clk), .port_b_clock_i(b_clk), .port_c_clock_i(c_clk),
    .queue_one_master_reset_n_i(mrst1_n), .queue_two_master_reset_n_i(mrst2_n),
    .endian_timing_select_i(endian_sel), .offset_select_i(offset_sel), .port_a_select_n_i(a_sel_n),
    .port_a_enable_i(a_en), .port_a_write_i(a_dir), .port_a_data_i(a_wire), .port_a_data_o(a_q),
    .port_a_data_oe_o(a_oe), .port_a_empty_or_out_ready_o(a_ef), .port_a_full_or_in_ready_o(a_ff),
    .port_a_almost_empty_n_o(a_ae_n), .port_a_almost_full_n_o(a_af_n), .port_b_select_n_i(b_sel_n),
    .port_b_data_o(b_q), .port_b_data_oe_o(b_oe), .port_b_empty_or_out_ready_o(b_ef),
    .port_b_almost_empty_n_o(b_ae_n), .port_c_write_enable_i(c_we), .port_c_data_i(c_d),
    .port_c_full_or_in_ready_o(c_ff), .port_c_almost_full_n_o(c_af_n));
  port_agent port_agent_i (.clk_i(clk_i), .port_a_clock_o(a_clk), .port_b_clock_o(b_clk),
    .port_c_clock_o(c_clk), .a_sel_n_o(a_sel_n), .a_en_o(a_en), .a_wr_o(a_dir), .a_drv_o(a_drv),
    .a_wire_i(a_wire), .a_oe_i(a_oe), .b_sel_n_o(b_sel_n), .b_data_i(b_q), .b_oe_i(b_oe),
    .c_we_o(c_we), .c_data_o(c_d));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [35:0] pat(input int k);
    return {4'h9, k[15:0], ~k[15:0]};
  endfunction
  task automatic settle();
    repeat (30) @(negedge clk_i);
  endtask
  // the select pin keeps its reset level afterwards, so endian and timing go together
  task automatic mreset(input logic e, input logic [1:0] s);
    @(negedge clk_i);
    mrst1_n    = 1'b0;
    mrst2_n    = 1'b0;
    endian_sel = e;
    offset_sel = s;
    repeat (60) @(negedge clk_i);
    mrst1_n = 1'b1;
    mrst2_n = 1'b1;
    big     = e;
    fall_through_mode    = e != fifo_pkg::STD_TIMING;
    settle();
  endtask
  task automatic a_wr(input logic [35:0] d);
    port_agent_i.a_op(1'b0, 1'b1, 1'b1, d, fall_through_mode, q36, oe);
  endtask
  task automatic a_rd(input logic [35:0] exp);
    port_agent_i.a_op(1'b0, 1'b1, 1'b0, 36'h0, fall_through_mode, q36, oe);
    chk_bit(oe, 1'b1);
    chk_word(q36, exp);
  endtask
  task automatic b_rd(input logic [35:0] exp);
    for (int h = 0; h < 2; h++) begin
      port_agent_i.b_read(fall_through_mode, q18, oe);
      chk_bit(oe, 1'b1);
      chk_word({18'h0, q18}, {18'h0, (big ^ h[0]) ? exp[35:18] : exp[17:0]});
    end
  endtask
  task automatic c_wr(input logic [35:0] d);
    port_agent_i.c_write(big ? d[35:18] : d[17:0]);
    port_agent_i.c_write(big ? d[17:0] : d[35:18]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (8) @(negedge clk_i);
    chk_bit(a_ff, 1'b0);
    chk_bit(b_oe, 1'b0);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_bit(a_oe, 1'b0);
    chk_bit(b_oe, 1'b0);
    foreach (rows[r]) begin
      mreset(rows[r].endian, rows[r].ofs_sel);
      chk_word(a_q, 36'h0);
      chk_word({18'h0, b_q}, 36'h0);
      chk_bit(a_ff, 1'b1);
      chk_bit(c_ff, 1'b1);
      chk_bit(a_ef, 1'b0);
      for (int k = 0; k <= rows[r].ofs; k++) begin
        if (k == rows[r].ofs) begin
          settle();
          chk_bit(b_ae_n, 1'b0);
        end
        a_wr(pat(k));
      end
      c_wr(~pat(0));
      c_wr(~pat(1));
      settle();
      chk_bit(b_ae_n, 1'b1);
      chk_bit(b_ef, 1'b1);
      chk_bit(a_ae_n, 1'b0);
      chk_bit(a_ef, 1'b1);
      for (int k = 0; k <= rows[r].ofs; k++) begin
        b_rd(pat(k));
      end
      a_rd(~pat(0));
      a_rd(~pat(1));
      settle();
      chk_bit(b_ef, 1'b0);
      chk_bit(a_ef, 1'b0);
    end
    mreset(fifo_pkg::BIG_ENDIAN, fifo_pkg::OFS_SEL_8);
    port_agent_i.a_op(1'b1, 1'b1, 1'b0, 36'h0, 1'b0, q36, oe);
    chk_bit(oe, 1'b0);
    port_agent_i.a_op(1'b1, 1'b1, 1'b1, pat(300), 1'b0, q36, oe);
    port_agent_i.a_op(1'b0, 1'b0, 1'b1, pat(301), 1'b0, q36, oe);
    settle();
    chk_bit(b_ef, 1'b0);
    chk_bit(b_oe, 1'b0);
    for (int k = 0; k <= DEPTH; k++) begin
      if (k == DEPTH - fifo_pkg::OFS_8 - 1 || k == DEPTH - fifo_pkg::OFS_8) begin
        settle();
        chk_bit(a_af_n, logic'(k < DEPTH - fifo_pkg::OFS_8));
        chk_bit(c_af_n, logic'(k < DEPTH - fifo_pkg::OFS_8));
      end
      a_wr(pat(k));
      c_wr(~pat(k));
    end
    settle();
    chk_bit(a_ff, 1'b0);
    chk_bit(c_ff, 1'b0);
    chk_bit(a_ae_n, 1'b1);
    for (int k = 0; k < DEPTH; k++) begin
      b_rd(pat(k));
      a_rd(~pat(k));
    end
    settle();
    chk_bit(b_ef, 1'b0);
    w = pat(DEPTH - 1);
    port_agent_i.b_read(1'b0, q18, oe);
    chk_word({18'h0, q18}, {18'h0, w[17:0]});
    port_agent_i.a_op(1'b0, 1'b1, 1'b0, 36'h0, 1'b0, q36, oe);
    chk_word(q36, ~w);
    print_verdict();
  end
endmodule
